// file: option_shadow_pkg.sv
// package: register map, field layout and reset values of the option byte shadow registers
// Notes on behaviour
// - user data loaded into status bits 31:16
// - user byte loaded into status bits 15:8
// - security level: 00 none, 01 low, 11 high
// - option byte complement mismatch sets error, byte 0xFF
// - bank zero mask loaded, full 32 bits
// - misc mask: eeprom 23:16, dataflash 15:8, bank1 7:0
// - lock key, load, size, allocation loaded after reset
// - config fields writable only while lock clear
// - lock key 0x33CC sets lock, blocks config
// - software sets change command, cleared when busy drops
// - block one mismatch sets error, value all ones
// - product code at 0x100, read only, constant
package option_shadow_pkg;
    // -------------------------------------------------------------
    // register offsets (byte addresses)
    // -------------------------------------------------------------
    localparam logic [11:0] OFS_OPTION_STATUS = 12'h05C;
    localparam logic [11:0] OFS_WP_BANK0 = 12'h060;
    localparam logic [11:0] OFS_WP_MISC = 12'h064;
    localparam logic [11:0] OFS_SEC_CTRL = 12'h068;
    localparam logic [11:0] OFS_PRODUCT_CODE = 12'h100;
    localparam logic [11:0] OFS_IRQ_STATUS = 12'h070;
    localparam logic [11:0] OFS_IRQ_MASK = 12'h074;
    // -------------------------------------------------------------
    // field positions
    // -------------------------------------------------------------
    localparam int SEC_LOCK_BIT = 2;
    localparam int SEC_CMD_BIT = 1;
    localparam int SEC_ERR_BIT = 0;
    localparam int SEC_LOAD_BIT = 15;
    localparam int IRQ_OPT_ERR_BIT = 0;
    localparam int IRQ_SEC_ERR_BIT = 1;
    localparam int IRQ_CMD_DONE_BIT = 2;
    // -------------------------------------------------------------
    // constant values
    // -------------------------------------------------------------
    localparam logic [15:0] LOCK_KEY_MAGIC = 16'h33CC;
    localparam logic [7:0] BYTE_ERASED = 8'hFF;
    localparam logic [31:0] WORD_ERASED = 32'hFFFFFFFF;
    localparam logic [1:0] LEVEL_RESERVED = 2'h2;
    localparam logic [1:0] LEVEL_HIGH = 2'h3;
    localparam logic [31:0] RESET_WORD = 32'h00000000;
    localparam logic [2:0] RESET_IRQ = 3'h0;
    // arbitrary neutral product code
    localparam logic [31:0] PRODUCT_CODE_VALUE = 32'h5A5A0001;
endpackage

// file: option_byte_check.sv
// module: checks one option byte against its stored complement
`timescale 1ns/100ps
module option_byte_check (
    input wire logic [7:0] rawByte,
    input wire logic [7:0] rawComplement,
    output logic [7:0] goodByte,
    output logic mismatch
);
    // ------------------------------------------------------------
    // compare and substitute
    // ------------------------------------------------------------
    always_comb begin
        mismatch = (rawByte != ~rawComplement);
        goodByte = mismatch ? option_shadow_pkg::BYTE_ERASED : rawByte;
    end
endmodule

// file: option_byte_shadow_regs.sv
// module: option byte shadow registers behind an APB slave
`timescale 1ns/100ps
module option_byte_shadow_regs (
    input wire logic clk_sys,
    input wire logic resetn,
    input wire logic [11:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [15:0] optUserData,   // raw option block words
    input wire logic [15:0] optUserDataN,  // complement of user data
    input wire logic [7:0] optUserByte,
    input wire logic [7:0] optUserByteN,
    input wire logic [7:0] optLevelByte,   // level byte, level in bits 1:0
    input wire logic [7:0] optLevelByteN,
    input wire logic [31:0] optBank0Mask,
    input wire logic [31:0] optBank0MaskN,
    input wire logic [23:0] optMiscMask,
    input wire logic [23:0] optMiscMaskN,
    input wire logic [31:0] optBlock1,     // lock key, load, size, allocation
    input wire logic [31:0] optBlock1N,
    input wire logic flashBusy,            // from the flash engine, same clock
    output logic secondaryChangeCmd,
    output logic irq
);
    // ------------------------------------------------------------
    // byte-wise complement checks of option block 0
    // ------------------------------------------------------------
    localparam int NB = 11;                // bytes checked in block 0: 2+1+1+4+3
    logic [8*NB-1:0] rawBytes;
    logic [8*NB-1:0] rawCompl;
    logic [8*NB-1:0] goodBytes;
    logic [NB-1:0] byteBad;
    assign rawBytes = {optMiscMask, optBank0Mask, optLevelByte, optUserByte, optUserData};
    assign rawCompl = {optMiscMaskN, optBank0MaskN, optLevelByteN, optUserByteN, optUserDataN};
    genvar g;
    generate
        for (g = 0; g < NB; g++) begin : gCheck
            option_byte_check uCheck (
                .rawByte(rawBytes[8*g +: 8]),
                .rawComplement(rawCompl[8*g +: 8]),
                .goodByte(goodBytes[8*g +: 8]),
                .mismatch(byteBad[g])
            );
        end
    endgenerate

    // block 1 is taken as one word: any mismatch erases all of it
    logic block1Bad;
    logic [31:0] block1Good;
    assign block1Bad = (optBlock1 != ~optBlock1N);
    assign block1Good = block1Bad ? option_shadow_pkg::WORD_ERASED : optBlock1;

    // ------------------------------------------------------------
    // load sequencer: one capture cycle after reset release
    // ------------------------------------------------------------
    // why: async reset may only load constants, so the straps are taken
    // by a clocked capture; the bus waits until it is done
    typedef enum logic [1:0] {ST_LOAD = 2'b01, ST_RUN = 2'b10} load_e;
    load_e state;
    load_e next_state;
    always_comb begin
        case (state)
            ST_LOAD: next_state = ST_RUN;
            ST_RUN: next_state = ST_RUN;
            default: next_state = ST_LOAD;
        endcase
    end
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            state <= ST_LOAD;
        end else begin
            state <= next_state;
        end
    end
    logic loading;
    assign loading = (state == ST_LOAD);

    // ------------------------------------------------------------
    // shadow state
    // ------------------------------------------------------------
    logic [15:0] userData;
    logic [7:0] userByte;
    logic [1:0] secLevel;
    logic optErr;
    logic [31:0] bank0Mask;
    logic [23:0] miscMask;
    logic [15:0] lockKey;
    logic eeprom_load_enable;
    logic [3:0] eeprom_size;
    logic [3:0] epAlloc;
    logic secErr;
    logic cmd;
    logic [2:0] irqStatus;                 // sticky events, write one to clear
    logic [2:0] irqMask;
    logic [15:0] next_userData;
    logic [7:0] next_userByte;
    logic [1:0] next_secLevel;
    logic next_optErr;
    logic [31:0] next_bank0Mask;
    logic [23:0] next_miscMask;
    logic [15:0] next_lockKey;
    logic next_eeprom_load_enable;
    logic [3:0] next_eeprom_size;
    logic [3:0] next_epAlloc;
    logic next_secErr;
    logic next_cmd;
    logic [2:0] next_irqStatus;
    logic [2:0] next_irqMask;

    // lock follows the key directly
    logic secLock;
    assign secLock = (lockKey == option_shadow_pkg::LOCK_KEY_MAGIC);

    // bus strobes: access phase with one wait cycle, none while loading
    logic wrEn;
    logic rdEn;
    logic [2:0] cmdDoneEvt;
    logic busyQ;                           // busy of the previous cycle
    assign wrEn = psel && penable && pwrite && pready && !loading;
    assign rdEn = psel && penable && !pwrite && !loading;

    // decodes an offset into a hit
    function automatic logic hit(input logic [11:0] a, input logic [11:0] ofs);
        hit = (a[11:2] == ofs[11:2]);
    endfunction

    // ------------------------------------------------------------
    // next values of the shadows
    // ------------------------------------------------------------
    always_comb begin
        next_userData = userData;
        next_userByte = userByte;
        next_secLevel = secLevel;
        next_optErr = optErr;
        next_bank0Mask = bank0Mask;
        next_miscMask = miscMask;
        next_lockKey = lockKey;
        next_eeprom_load_enable = eeprom_load_enable;
        next_eeprom_size = eeprom_size;
        next_epAlloc = epAlloc;
        next_secErr = secErr;
        next_cmd = cmd;
        next_irqMask = irqMask;
        next_irqStatus = irqStatus;
        cmdDoneEvt = 3'h0;
        if (loading) begin
            next_userData = goodBytes[15:0];
            next_userByte = goodBytes[23:16];
            next_secLevel = goodBytes[25:24];
            next_optErr = |byteBad;
            next_bank0Mask = goodBytes[63:32];
            next_miscMask = goodBytes[87:64];
            next_lockKey = block1Good[31:16];
            next_eeprom_load_enable = block1Good[option_shadow_pkg::SEC_LOAD_BIT];
            next_eeprom_size = block1Good[11:8];
            next_epAlloc = block1Good[7:4];
            next_secErr = block1Bad;
        end else begin
            // command clears on the busy falling edge
            if (cmd && busyQ && !flashBusy) begin
                next_cmd = 1'b0;
                cmdDoneEvt[option_shadow_pkg::IRQ_CMD_DONE_BIT] = 1'b1;
            end
            if (wrEn && hit(paddr, option_shadow_pkg::OFS_SEC_CTRL)) begin
                if (!secLock) begin
                    next_lockKey = pwdata[31:16];
                    next_eeprom_load_enable = pwdata[option_shadow_pkg::SEC_LOAD_BIT];
                    next_eeprom_size = pwdata[11:8];
                    next_epAlloc = pwdata[7:4];
                end
                // software may only set the command, never clear it
                if (pwdata[option_shadow_pkg::SEC_CMD_BIT]) begin
                    next_cmd = 1'b1;
                end
            end
            if (wrEn && hit(paddr, option_shadow_pkg::OFS_IRQ_MASK)) begin
                next_irqMask = pwdata[2:0];
            end
            if (wrEn && hit(paddr, option_shadow_pkg::OFS_IRQ_STATUS)) begin
                next_irqStatus = irqStatus & ~pwdata[2:0];
            end
        end
        // set wins over a clear in the same cycle
        next_irqStatus = next_irqStatus | cmdDoneEvt;
        if (state == ST_LOAD) begin
            next_irqStatus[option_shadow_pkg::IRQ_OPT_ERR_BIT] = |byteBad;
            next_irqStatus[option_shadow_pkg::IRQ_SEC_ERR_BIT] = block1Bad;
        end
    end

    // ------------------------------------------------------------
    // shadow registers
    // ------------------------------------------------------------
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            userData <= option_shadow_pkg::RESET_WORD[15:0];
            userByte <= option_shadow_pkg::RESET_WORD[7:0];
            secLevel <= option_shadow_pkg::RESET_WORD[1:0];
            optErr <= 1'b0;
            bank0Mask <= option_shadow_pkg::RESET_WORD;
            miscMask <= option_shadow_pkg::RESET_WORD[23:0];
            lockKey <= option_shadow_pkg::RESET_WORD[15:0];
            eeprom_load_enable <= 1'b0;
            eeprom_size <= option_shadow_pkg::RESET_WORD[3:0];
            epAlloc <= option_shadow_pkg::RESET_WORD[3:0];
            secErr <= 1'b0;
            cmd <= 1'b0;
            irqStatus <= option_shadow_pkg::RESET_IRQ;
            irqMask <= option_shadow_pkg::RESET_IRQ;
            busyQ <= 1'b0;
        end else begin
            userData <= next_userData;
            userByte <= next_userByte;
            secLevel <= next_secLevel;
            optErr <= next_optErr;
            bank0Mask <= next_bank0Mask;
            miscMask <= next_miscMask;
            lockKey <= next_lockKey;
            eeprom_load_enable <= next_eeprom_load_enable;
            eeprom_size <= next_eeprom_size;
            epAlloc <= next_epAlloc;
            secErr <= next_secErr;
            cmd <= next_cmd;
            irqStatus <= next_irqStatus;
            irqMask <= next_irqMask;
            busyQ <= flashBusy;
        end
    end

    // ------------------------------------------------------------
    // read mux and bus answer
    // ------------------------------------------------------------
    logic [31:0] next_prdata;
    logic mapped;
    always_comb begin
        next_prdata = prdata;
        mapped = 1'b1;
        case (1'b1)
            hit(paddr, option_shadow_pkg::OFS_OPTION_STATUS):
                next_prdata = {userData, userByte, 5'h00, secLevel, optErr};
            hit(paddr, option_shadow_pkg::OFS_WP_BANK0):
                next_prdata = bank0Mask;
            hit(paddr, option_shadow_pkg::OFS_WP_MISC):
                next_prdata = {8'h00, miscMask};
            hit(paddr, option_shadow_pkg::OFS_SEC_CTRL):
                next_prdata = {lockKey, eeprom_load_enable, 3'h0, eeprom_size, epAlloc,
                               1'b0, secLock, cmd, secErr};
            hit(paddr, option_shadow_pkg::OFS_PRODUCT_CODE):
                next_prdata = option_shadow_pkg::PRODUCT_CODE_VALUE;
            hit(paddr, option_shadow_pkg::OFS_IRQ_STATUS):
                next_prdata = {29'h0, irqStatus};
            hit(paddr, option_shadow_pkg::OFS_IRQ_MASK):
                next_prdata = {29'h0, irqMask};
            default: begin
                next_prdata = 32'h00000000;
                mapped = 1'b0;
            end
        endcase
        if (!rdEn) begin
            next_prdata = prdata;
        end
    end
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            prdata <= option_shadow_pkg::RESET_WORD;
        end else begin
            prdata <= next_prdata;
        end
    end
    // read data is registered, so the answer comes one cycle into the access
    logic accQ;
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            accQ <= 1'b0;
        end else begin
            accQ <= psel && penable && !pready && !loading;
        end
    end
    assign pready = accQ;
    logic errQ;
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            errQ <= 1'b0;
        end else begin
            errQ <= psel && penable && !pready && !mapped;
        end
    end
    assign pslverr = accQ && errQ;
    assign secondaryChangeCmd = cmd;
    assign irq = |(irqStatus & irqMask);

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    sequence sWriteKeyUnlocked;
        wrEn && hit(paddr, option_shadow_pkg::OFS_SEC_CTRL) && !secLock;
    endsequence
    a_lock_blocks_write: assert property (@(posedge clk_sys) disable iff (!resetn)
        wrEn && hit(paddr, option_shadow_pkg::OFS_SEC_CTRL) && secLock |=> $stable(lockKey))
        else $error("locked control register changed");
    a_key_write_lands: assert property (@(posedge clk_sys) disable iff (!resetn)
        sWriteKeyUnlocked |=> lockKey == $past(pwdata[31:16]))
        else $error("unlocked key write lost");
    a_lock_from_key: assert property (@(posedge clk_sys) disable iff (!resetn)
        lockKey == 16'h33CC |-> secLock)
        else $error("lock not set for magic key");
    a_cmd_clears: assert property (@(posedge clk_sys) disable iff (!resetn)
        cmd && busyQ && !flashBusy && !loading |=> !cmd)
        else $error("command not cleared at busy fall");
    a_load_erased: assert property (@(posedge clk_sys) disable iff (!resetn)
        loading && block1Bad |=> secErr && lockKey == 16'hFFFF)
        else $error("block one error load wrong");
    a_opt_err_load: assert property (@(posedge clk_sys) disable iff (!resetn)
        loading |=> optErr == ($past(byteBad) != '0))
        else $error("option error flag wrong");
    a_user_data_load: assert property (@(posedge clk_sys) disable iff (!resetn)
        loading |=> userData == $past(goodBytes[15:0]) && userByte == $past(goodBytes[23:16]))
        else $error("user data not loaded");
    a_mask_load: assert property (@(posedge clk_sys) disable iff (!resetn)
        loading |=> bank0Mask == $past(goodBytes[63:32]) ##1 $stable(bank0Mask))
        else $error("bank zero mask wrong");
    a_misc_load: assert property (@(posedge clk_sys) disable iff (!resetn)
        loading |=> miscMask == $past(goodBytes[87:64]))
        else $error("misc mask wrong");
    a_no_ready_load: assert property (@(posedge clk_sys) disable iff (!resetn)
        loading |=> !pready)
        else $error("answer before load done");
    a_pid_const: assert property (@(posedge clk_sys) disable iff (!resetn)
        rdEn && hit(paddr, option_shadow_pkg::OFS_PRODUCT_CODE) |=>
            prdata == option_shadow_pkg::PRODUCT_CODE_VALUE)
        else $error("product code read wrong");
    a_level_valid: assert property (@(posedge clk_sys) disable iff (!resetn)
        loading && byteBad[3] |=> secLevel == option_shadow_pkg::LEVEL_HIGH)
        else $error("bad level byte not read as high");
endmodule

// file: option_byte_shadow_regs_test.sv
// testbench: option byte shadow registers, load after reset, apb access, lock, command, interrupt
`timescale 1ns/100ps
module option_byte_shadow_regs_test;
    // -------------------------------------------------------------
    // stimulus and observed signals
    // -------------------------------------------------------------
    logic clk_sys = 1'b0; // 200 MHz system clock
    logic resetn = 1'b0; // active low, asynchronous
    logic [11:0] paddr = 12'h000;
    logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, flashBusy = 1'b0;
    logic [31:0] pwdata = 32'h00000000;
    logic [31:0] prdata;
    logic pready, pslverr, secondaryChangeCmd, irq;
    logic [15:0] optUserData = 16'h0000, optUserDataN = 16'hFFFF;
    logic [7:0] optUserByte = 8'h00, optUserByteN = 8'hFF, optLevelByte = 8'h00;
    logic [7:0] optLevelByteN = 8'hFF;
    logic [31:0] optBank0Mask = 32'h0, optBank0MaskN = 32'hFFFFFFFF, optBlock1 = 32'h0;
    logic [31:0] optBlock1N = 32'hFFFFFFFF;
    logic [23:0] optMiscMask = 24'h0, optMiscMaskN = 24'hFFFFFF;
    logic [33:0] notes[$]; // {is read, error, data} per access, oldest first
    logic [33:0] note;
    logic [31:0] w1, w2; // expected contents of the control register
    logic [1:0] levels[3] = '{2'h0, 2'h1, 2'h3};
    int err_total = 0, n_checks = 0;

    option_byte_shadow_regs dut (
        .clk_sys(clk_sys), .resetn(resetn), .paddr(paddr), .psel(psel), .penable(penable),
        .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .optUserData(optUserData), .optUserDataN(optUserDataN), .optUserByte(optUserByte),
        .optUserByteN(optUserByteN), .optLevelByte(optLevelByte),
        .optLevelByteN(optLevelByteN), .optBank0Mask(optBank0Mask),
        .optBank0MaskN(optBank0MaskN), .optMiscMask(optMiscMask), .optMiscMaskN(optMiscMaskN),
        .optBlock1(optBlock1), .optBlock1N(optBlock1N), .flashBusy(flashBusy),
        .secondaryChangeCmd(secondaryChangeCmd), .irq(irq)
    );

    // free running clock, 5 ns period
    always #2.5 clk_sys = ~clk_sys;

    // -------------------------------------------------------------
    // shared tasks
    // -------------------------------------------------------------
    task automatic final_report();
        $display("checks %0d, mismatches %0d", n_checks, err_total);
        if (err_total == 0 && n_checks > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    // one comparison, counted; four-state so unknown never matches
    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
        n_checks++;
        if (got !== exp) begin
            err_total++;
            $display("BAD %0t %s: got %h want %h", $time, what, got, exp);
        end
    endtask

    // apb master: word transfers only, write data driven as given, reserved bits included
    task automatic apb(input logic [11:0] a, input logic w, input logic [31:0] d,
                       input logic [31:0] e, input logic er);
        int k;
        @(posedge clk_sys);
        psel <= 1'b1;
        paddr <= a;
        pwrite <= w;
        pwdata <= d;
        notes.push_back({~w, er, e});
        @(posedge clk_sys);
        penable <= 1'b1;
        k = 0;
        // held until pready is seen high at a rising edge; load cycle may stretch it
        do begin
            @(posedge clk_sys);
            k++;
        end while (pready !== 1'b1 && k < 40);
        psel <= 1'b0;
        penable <= 1'b0;
        if (pready !== 1'b1) begin
            err_total++;
            $display("BAD %0t no ready", $time);
            final_report();
        end
    endtask

    // reset with fresh option words; bad breaks user byte, level byte and block one
    task automatic do_reset(input logic [1:0] lvl, input logic bad);
        logic [31:0] r;
        logic [15:0] key;
        r = $urandom();
        key = (r[31:16] == 16'h33CC) ? 16'h1111 : r[31:16];
        @(posedge clk_sys);
        resetn <= 1'b0;
        optUserData <= r[15:0];
        optUserDataN <= ~r[15:0];
        optUserByte <= r[23:16];
        optUserByteN <= bad ? r[23:16] : ~r[23:16];
        optLevelByte <= {r[29:24], lvl};
        optLevelByteN <= bad ? {r[29:24], lvl} : ~{r[29:24], lvl};
        optBank0Mask <= $urandom();
        optMiscMask <= r[31:8];
        optBlock1 <= {key, r[0], 3'h0, r[11:4], 4'h0};
        optBlock1N <= bad ? {key, r[0], 3'h0, r[11:4], 4'h0} : ~{key, r[0], 3'h0, r[11:4], 4'h0};
        @(posedge clk_sys);
        optBank0MaskN <= ~optBank0Mask;
        optMiscMaskN <= ~optMiscMask;
        repeat (3) @(posedge clk_sys);
        chk(prdata | {pready, pslverr, secondaryChangeCmd, irq}, 32'h0, "outputs in reset");
        resetn <= 1'b1;
    endtask

    // -------------------------------------------------------------
    // response watcher: each ready takes the oldest note
    // -------------------------------------------------------------
    always @(posedge clk_sys) begin
        if (pready === 1'b1) begin
            if (notes.size() == 0) begin
                chk(32'h1, 32'h0, "ready without request");
            end else begin
                note = notes.pop_front();
                chk({31'h0, pslverr}, {31'h0, note[32]}, "slave error");
                if (note[33]) begin
                    chk(prdata, note[31:0], "read data");
                end
            end
        end
    end

    // -------------------------------------------------------------
    // main sequence
    // -------------------------------------------------------------
    initial begin
        void'($urandom(11));
        // every security level, first read right after release
        foreach (levels[i]) begin
            do_reset(levels[i], 1'b0);
            apb(12'h05C, 1'b0, 32'h0, {optUserData, optUserByte, 5'h0, levels[i], 1'b0}, 1'b0);
            apb(12'h060, 1'b0, 32'h0, optBank0Mask, 1'b0);
            apb(12'h064, 1'b0, 32'h0, {8'h00, optMiscMask}, 1'b0);
            apb(12'h068, 1'b0, 32'h0, optBlock1, 1'b0);
            apb(12'h100, 1'b0, 32'h0, option_shadow_pkg::PRODUCT_CODE_VALUE, 1'b0);
        end
        // read-only places ignore writes; unmapped address errors
        apb(12'h100, 1'b1, 32'hFFFFFFFF, 32'h0, 1'b0);
        apb(12'h100, 1'b0, 32'h0, option_shadow_pkg::PRODUCT_CODE_VALUE, 1'b0);
        apb(12'h05C, 1'b1, 32'h0, 32'h0, 1'b0);
        apb(12'h05C, 1'b0, 32'h0, {optUserData, optUserByte, 5'h0, 2'h3, 1'b0}, 1'b0);
        apb(12'h080, 1'b0, 32'h0, 32'h0, 1'b1);
        // unlocked rewrite, then lock key, then refused rewrite
        w1 = {16'h1234, 1'b1, 3'h0, 4'h9, 4'h6, 4'h0};
        apb(12'h068, 1'b1, w1, 32'h0, 1'b0);
        apb(12'h068, 1'b0, 32'h0, w1, 1'b0);
        w2 = {16'h33CC, 1'b0, 3'h0, 4'hA, 4'h5, 4'h0};
        apb(12'h068, 1'b1, w2, 32'h0, 1'b0);
        apb(12'h068, 1'b0, 32'h0, w2 | 32'h4, 1'b0);
        apb(12'h068, 1'b1, 32'h0000F0F0, 32'h0, 1'b0);
        apb(12'h068, 1'b0, 32'h0, w2 | 32'h4, 1'b0);
        // change command, cleared when busy drops
        apb(12'h068, 1'b1, w2 | 32'h2, 32'h0, 1'b0);
        @(negedge clk_sys);
        chk({31'h0, secondaryChangeCmd}, 32'h1, "command set");
        apb(12'h068, 1'b0, 32'h0, w2 | 32'h6, 1'b0);
        @(posedge clk_sys);
        flashBusy <= 1'b1;
        repeat (3) @(posedge clk_sys);
        flashBusy <= 1'b0;
        for (int k = 0; k < 10 && secondaryChangeCmd !== 1'b0; k++) @(negedge clk_sys);
        chk({31'h0, secondaryChangeCmd}, 32'h0, "command cleared");
        // command done event: raise, mask, clear
        apb(12'h070, 1'b0, 32'h0, 32'h4, 1'b0);
        chk({31'h0, irq}, 32'h0, "irq masked");
        apb(12'h074, 1'b1, 32'h4, 32'h0, 1'b0);
        @(negedge clk_sys);
        chk({31'h0, irq}, 32'h1, "irq raised");
        apb(12'h070, 1'b1, 32'h4, 32'h0, 1'b0);
        @(negedge clk_sys);
        chk({31'h0, irq}, 32'h0, "irq cleared");
        // complement mismatches: bytes and block one read as erased
        do_reset(2'h1, 1'b1);
        apb(12'h05C, 1'b0, 32'h0, {optUserData, 8'hFF, 8'h07}, 1'b0);
        apb(12'h068, 1'b0, 32'h0, 32'hFFFF8FF1, 1'b0);
        apb(12'h070, 1'b0, 32'h0, 32'h3, 1'b0);
        apb(12'h074, 1'b1, 32'h2, 32'h0, 1'b0);
        @(negedge clk_sys);
        chk({31'h0, irq}, 32'h1, "irq on block error");
        apb(12'h070, 1'b1, 32'h2, 32'h0, 1'b0);
        apb(12'h070, 1'b0, 32'h0, 32'h1, 1'b0);
        chk({31'h0, irq}, 32'h0, "irq after clear");
        repeat (4) @(posedge clk_sys);
        final_report();
    end
endmodule
